// ---- pasl_top.sv ----
// pasl_top: auxiliary status, indicator mode and indicator behaviour registers
// assumes: status inputs come from logic on clk; register port strobes are one cycle
// Functional notes
// - Aux bit 15 copies basic-status negotiation done when negotiation is on, else live link.
// - Aux bit 14 is the inverse of negotiation enable, also set by media sense with FX mode.
// - Aux bit 13 is one when automatic crossover swapped the pairs internally.
// - Aux bit 12 is one when pairs C and D are found swapped.
// - Aux bits 11 to 8 flag inverted polarity on pairs A to D.
// - Timeout code sits in bits 7 and 2, 7 high, meaning 1 to 4 s, reset code 01.
// - Aux bits 4:3 give speed: 00 ten, 01 hundred, 10 gigabit, 11 reserved.
// - Aux bits 1:0 give media: 00 none, 01 copper, 10 fiber, 11 reserved, reset 00.
// - Four writable 4-bit mode selectors reset to 1000, 0000, 0010, 0001 for outputs 3 to 0.
// - Combine-disable zero lets fiber feed link and activity, one keeps copper only.
// - Activity select one splits transmit onto activity and receive onto fiber activity.
// - Pulsing enable chops active outputs at 5 kHz with a set duty.
// - Rate field picks blink and stretch 400, 200, 100 or 50 ms, reset 01.
// - Only the first port's rate field acts, and it drives every port.
// - Per-output combine disable zero mixes link with activity, one shows base only except in activity-only modes 9, A and B.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pasl_defs.svh"
module pasl_top import pasl_pkg::*; #(
  parameter int MS_CYC  = `PASL_CLK_HZ / `PASL_MS_PER_S,
  parameter int PWM_CYC = `PASL_CLK_HZ / `PASL_PWM_HZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [4:0] reg_addr,
  input  wire pasl_word_t reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output pasl_word_t      reg_rdata,
  // negotiation and media status
  input  wire logic       an_en,
  input  wire logic       an_done,
  input  wire logic       link_up,
  input  wire logic       automatic_media_sense,
  input  wire logic       fx_sel,
  input  wire logic       xover,
  input  wire logic       cd_swap,
  input  wire logic [3:0] pol_inv,
  input  wire logic       full_duplex_flag,
  input  wire logic [1:0] speed,
  input  wire logic [1:0] media,
  // indicator sources
  input  wire logic       link_cu,
  input  wire logic       link_fi,
  input  wire logic       tx_cu,
  input  wire logic       rx_cu,
  input  wire logic       tx_fi,
  input  wire logic       rx_fi,
  input  wire logic       col,
  input  wire logic [6:0] pwm_duty,
  // rate sharing between ports
  input  wire logic       first_port,
  input  wire pasl_rate_t rate_in,
  output pasl_rate_t      rate_out,
  // power saving
  output logic            ps_en,
  output logic [1:0]      ps_timeout_code,
  // indicator outputs
  output logic            indicator_output_zero,
  output logic            indicator_output_one,
  output logic            indicator_output_two,
  output logic            indicator_output_three
);
  logic       rst_meta_q, rst_n;
  pasl_word_t aux_q, aux_d, mode_q, mode_d, beh_q, beh_d, rdata_q, rdata_d, aux_rd;
  pasl_rate_t rate_eff;
  pasl_ms_t   t_ms;
  logic       ms_tick, blink_ph, pwm_on, an_cmp, an_dis, cdis, asel;
  logic       lk, tx_all, rx_all, act_main, fi_act, s10, s100, s1g;
  logic [3:0] ind;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // status view
  always_comb begin
    an_cmp = an_en ? an_done : link_up;
    an_dis = ~an_en | (automatic_media_sense & fx_sel);
    aux_rd = {an_cmp, an_dis, xover, cd_swap, pol_inv,
              aux_q[`PASL_B_TO_HI], aux_q[`PASL_B_PS_EN],
              full_duplex_flag, speed,
              aux_q[`PASL_B_TO_LO], media};
  end

  // register writes and read data
  always_comb begin
    aux_d = aux_q;
    mode_d = mode_q;
    beh_d = beh_q;
    if (reg_wr) begin
      case (reg_addr)
        `PASL_A_AUX:  aux_d = reg_wdata & `PASL_AUX_WMASK;
        `PASL_A_MODE: mode_d = reg_wdata;
        `PASL_A_BEH:  beh_d = reg_wdata & `PASL_BEH_WMASK;
        default:      aux_d = aux_q;
      endcase
    end
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        `PASL_A_AUX:  rdata_d = aux_rd;
        `PASL_A_MODE: rdata_d = mode_q;
        `PASL_A_BEH:  rdata_d = beh_q;
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_q <= `PASL_AUX_RST;
      mode_q <= `PASL_MODE_RST;
      beh_q <= `PASL_BEH_RST;
      rdata_q <= '0;
    end else begin
      aux_q <= aux_d;
      mode_q <= mode_d;
      beh_q <= beh_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign ps_en = aux_q[`PASL_B_PS_EN];
  assign ps_timeout_code = {aux_q[`PASL_B_TO_HI], aux_q[`PASL_B_TO_LO]};
  assign rate_out = beh_q[`PASL_B_RATE +: 2];
  assign rate_eff = first_port ? beh_q[`PASL_B_RATE +: 2] : rate_in;

  // source combining
  always_comb begin
    cdis = beh_q[`PASL_B_CDIS];
    asel = beh_q[`PASL_B_ASEL];
    lk = link_cu | (link_fi & ~cdis);
    tx_all = tx_cu | (tx_fi & ~cdis);
    rx_all = rx_cu | (rx_fi & ~cdis);
    act_main = asel ? tx_all : (tx_all | rx_all);
    fi_act = asel ? rx_all : (tx_fi | rx_fi);
    s10 = speed == `PASL_SPD_10;
    s100 = speed == `PASL_SPD_100;
    s1g = speed == `PASL_SPD_1G;
  end

  pasl_rate_gen #(.MS_CYC(MS_CYC), .PWM_CYC(PWM_CYC)) u_rate (
    .clk      (clk),
    .rst_n    (rst_n),
    .rate     (rate_eff),
    .duty     (pwm_duty),
    .ms_tick  (ms_tick),
    .blink_ph (blink_ph),
    .pwm_on   (pwm_on),
    .t_ms     (t_ms)
  );

  for (genvar i = 0; i < 4; i++) begin : g_lane
    logic b, a, ao;
    always_comb begin
      b = 1'b0;
      a = act_main;
      ao = 1'b0;
      case (mode_q[i*4 +: 4])
        4'h0: b = lk;
        4'h1: b = lk & s1g;
        4'h2: b = lk & s100;
        4'h3: b = lk & s10;
        4'h4: b = lk & (s100 | s1g);
        4'h5: b = lk & (s10 | s1g);
        4'h6: b = lk & (s10 | s100);
        4'h7: begin
          b = link_fi;
          a = fi_act;
        end
        4'h8: begin
          b = lk & full_duplex_flag;
          a = col;
        end
        4'h9: begin
          a = col;
          ao = 1'b1;
        end
        4'hA: ao = 1'b1;
        4'hB: begin
          a = fi_act;
          ao = 1'b1;
        end
        4'hC: begin
          b = link_cu;
          a = 1'b0;
        end
        4'hD: begin
          b = link_fi;
          a = 1'b0;
        end
        4'hE: a = 1'b0;
        default: begin
          b = 1'b1;
          a = 1'b0;
        end
      endcase
    end
    pasl_ind_lane u_lane (
      .clk      (clk),
      .rst_n    (rst_n),
      .ms_tick  (ms_tick),
      .blink_ph (blink_ph),
      .pwm_on   (pwm_on),
      .t_ms     (t_ms),
      .pulse_en (beh_q[`PASL_B_PULSE]),
      .str_sel  (beh_q[`PASL_B_STR + i]),
      .comb_dis (beh_q[`PASL_B_LCDIS + i]),
      .base     (b),
      .act      (a),
      .act_only (ao),
      .ind      (ind[i])
    );
  end

  assign indicator_output_zero  = ind[0];
  assign indicator_output_one   = ind[1];
  assign indicator_output_two   = ind[2];
  assign indicator_output_three = ind[3];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [4:0] ad);
    reg_rd && reg_addr == ad;
  endsequence
  sequence s_wr(logic [4:0] ad);
    reg_wr && reg_addr == ad;
  endsequence

  AST_ANC: assert property (s_rd(`PASL_A_AUX) |=>
    reg_rdata[15] == ($past(an_en) ? $past(an_done) : $past(link_up)))
    else $error("negotiation done bit wrong");
  AST_AND: assert property (s_rd(`PASL_A_AUX) |=>
    reg_rdata[14] == (!$past(an_en) || ($past(automatic_media_sense) && $past(fx_sel))))
    else $error("negotiation disabled bit wrong");
  AST_PAIR: assert property (s_rd(`PASL_A_AUX) |=>
    reg_rdata[13:8] == {$past(xover), $past(cd_swap), $past(pol_inv)})
    else $error("pair status bits wrong");
  AST_SPD_MED: assert property (s_rd(`PASL_A_AUX) |=>
    reg_rdata[5:3] == {$past(full_duplex_flag), $past(speed)} && reg_rdata[1:0] == $past(media))
    else $error("duplex, speed or media bits wrong");
  AST_TO: assert property (s_wr(`PASL_A_AUX) ##2 s_rd(`PASL_A_AUX) |=>
    ps_timeout_code == {$past(reg_wdata[7], 3), $past(reg_wdata[2], 3)}
    && reg_rdata[7] == $past(reg_wdata[7], 3) && reg_rdata[2] == $past(reg_wdata[2], 3))
    else $error("timeout code not kept");
  AST_MODE: assert property (s_wr(`PASL_A_MODE) ##2 s_rd(`PASL_A_MODE) |=>
    reg_rdata == $past(reg_wdata, 3))
    else $error("mode select not kept");
  AST_RST: assert property ($rose(rst_n) |->
    mode_q == 16'h8021 && beh_q[11:10] == 2'h1 && ps_timeout_code == 2'h1 && !ps_en)
    else $error("reset values wrong");
  AST_RATE0: assert property ($past(rate_eff) == 2'h0 |-> t_ms == 9'd400)
    else $error("slowest rate period wrong");
  AST_RATE3: assert property ($past(rate_eff) == 2'h3 |-> t_ms == 9'd50)
    else $error("fastest rate period wrong");
  AST_RATE1: assert property ($past(rate_eff) == 2'h1 |-> t_ms == 9'(`PASL_T1_MS))
    else $error("second rate period wrong");
  AST_RATE2: assert property ($past(rate_eff) == 2'h2 |-> t_ms == 9'(`PASL_T2_MS))
    else $error("third rate period wrong");
  AST_SHARE: assert property (!first_port && rate_in == 2'h3 && beh_q[`PASL_B_RATE +: 2] != 2'h3 |=>
    t_ms == 9'd50)
    else $error("shared rate not followed");
  AST_CU_ONLY: assert property (cdis && !link_cu && mode_q[3:0] == 4'h0 && beh_q[`PASL_B_LCDIS]
    |=> !indicator_output_zero)
    else $error("fiber leaked into copper-only indicator");
  AST_SPLIT: assert property (asel && !rx_all |-> !fi_act)
    else $error("fiber activity without receive");
  AST_UNMAP: assert property (reg_rd && (reg_addr < `PASL_A_AUX || reg_addr > `PASL_A_BEH) |=>
    reg_rdata == '0)
    else $error("unmapped read not zero");

  // register port behaviour
  AST_RD_ONE: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data held past its cycle");
  AST_UNMAP_WR: assert property (reg_wr && (reg_addr < `PASL_A_AUX || reg_addr > `PASL_A_BEH) |=>
    $stable(aux_q) && $stable(mode_q) && $stable(beh_q))
    else $error("unmapped write changed a register");
  AST_AUX_WR: assert property (s_wr(`PASL_A_AUX) |=> ps_en == $past(reg_wdata[`PASL_B_PS_EN]) &&
    ps_timeout_code == {$past(reg_wdata[`PASL_B_TO_HI]), $past(reg_wdata[`PASL_B_TO_LO])})
    else $error("power-save fields not written");
  AST_BEH_WR: assert property (s_wr(`PASL_A_BEH) |=>
    beh_q == ($past(reg_wdata) & `PASL_BEH_WMASK))
    else $error("behaviour register write wrong");
endmodule
`default_nettype wire

// ---- pasl_defs.svh ----
// pasl_defs.svh: offsets, field positions, reset values and timing figures
// assumes: included by every design module of the block
`ifndef PASL_DEFS_SVH
`define PASL_DEFS_SVH
// register offsets
`define PASL_A_AUX      5'h1C
`define PASL_A_MODE     5'h1D
`define PASL_A_BEH      5'h1E
// reset values and writable masks
`define PASL_AUX_RST    16'h0004
`define PASL_AUX_WMASK  16'h00C4
`define PASL_MODE_RST   16'h8021
`define PASL_BEH_RST    16'h0400
`define PASL_BEH_WMASK  16'hDDEF
// field positions
`define PASL_B_TO_HI    7
`define PASL_B_PS_EN    6
`define PASL_B_TO_LO    2
`define PASL_B_CDIS     15
`define PASL_B_ASEL     14
`define PASL_B_PULSE    12
`define PASL_B_RATE     10
`define PASL_B_STR      5
`define PASL_B_LCDIS    0
// speed codes
`define PASL_SPD_10     2'h0
`define PASL_SPD_100    2'h1
`define PASL_SPD_1G     2'h2
// timing
`define PASL_CLK_HZ     100000000
`define PASL_MS_PER_S   1000
`define PASL_PWM_HZ     5000
`define PASL_PWM_STEPS  100
`define PASL_T0_MS      400
`define PASL_T1_MS      200
`define PASL_T2_MS      100
`define PASL_T3_MS      50
`endif

// ---- pasl_pkg.sv ----
// pasl_pkg: shared types of the status and indicator block
// assumes: pasl_defs.svh supplies the numbers
package pasl_pkg;
  typedef logic [15:0] pasl_word_t;
  typedef logic [3:0]  pasl_mode_t;
  typedef logic [1:0]  pasl_rate_t;
  typedef logic [8:0]  pasl_ms_t;
endpackage

// ---- pasl_rate_gen.sv ----
// pasl_rate_gen: millisecond tick, blink phase, period and 5 kHz duty enable
// assumes: synchronous active-low reset from the top
`timescale 1ns/1ps
`default_nettype none
`include "pasl_defs.svh"
module pasl_rate_gen import pasl_pkg::*; #(
  parameter int MS_CYC  = `PASL_CLK_HZ / `PASL_MS_PER_S,
  parameter int PWM_CYC = `PASL_CLK_HZ / `PASL_PWM_HZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire pasl_rate_t rate,
  input  wire logic [6:0] duty,
  // timing outputs
  output logic            ms_tick,
  output logic            blink_ph,
  output logic            pwm_on,
  output pasl_ms_t        t_ms
);
  localparam int MW = $clog2(MS_CYC);
  localparam int SC = PWM_CYC / `PASL_PWM_STEPS;
  localparam int SW = $clog2(SC);
  logic [MW-1:0] ms_q, ms_d;
  logic [SW-1:0] sc_q, sc_d;
  logic [6:0]    st_q, st_d;
  pasl_ms_t      half_q, half_d, per_q, per_d;
  logic          tk_q, tk_d, ph_q, ph_d, on_q, on_d;

  always_comb begin
    case (rate)
      2'h0:    per_d = 9'(`PASL_T0_MS);
      2'h1:    per_d = 9'(`PASL_T1_MS);
      2'h2:    per_d = 9'(`PASL_T2_MS);
      default: per_d = 9'(`PASL_T3_MS);
    endcase
    tk_d = (ms_q == MW'(MS_CYC - 1));
    ms_d = tk_d ? '0 : ms_q + 1'b1;
    half_d = half_q;
    ph_d = ph_q;
    if (tk_q) begin
      if (half_q >= (per_q >> 1) - 9'h1) begin
        half_d = '0;
        ph_d = ~ph_q;
      end else begin
        half_d = half_q + 9'h1;
      end
    end
    sc_d = (sc_q == SW'(SC - 1)) ? '0 : sc_q + 1'b1;
    st_d = st_q;
    if (sc_q == SW'(SC - 1)) begin
      st_d = (st_q == 7'(`PASL_PWM_STEPS - 1)) ? '0 : st_q + 7'h1;
    end
    on_d = st_q < duty;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ms_q <= '0;
      sc_q <= '0;
      st_q <= '0;
      half_q <= '0;
      per_q <= 9'(`PASL_T1_MS);
      tk_q <= 1'b0;
      ph_q <= 1'b0;
      on_q <= 1'b0;
    end else begin
      ms_q <= ms_d;
      sc_q <= sc_d;
      st_q <= st_d;
      half_q <= half_d;
      per_q <= per_d;
      tk_q <= tk_d;
      ph_q <= ph_d;
      on_q <= on_d;
    end
  end

  assign ms_tick  = tk_q;
  assign blink_ph = ph_q;
  assign pwm_on   = on_q;
  assign t_ms     = per_q;
endmodule
`default_nettype wire

// ---- pasl_ind_lane.sv ----
// pasl_ind_lane: one indicator output with stretch, blink, combine and pulsing
// assumes: timing enables from pasl_rate_gen on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pasl_defs.svh"
module pasl_ind_lane import pasl_pkg::*; (
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // timing
  input  wire logic     ms_tick,
  input  wire logic     blink_ph,
  input  wire logic     pwm_on,
  input  wire pasl_ms_t t_ms,
  // control
  input  wire logic     pulse_en,
  input  wire logic     str_sel,
  input  wire logic     comb_dis,
  // sources
  input  wire logic     base,
  input  wire logic     act,
  input  wire logic     act_only,
  // output
  output logic          ind
);
  pasl_ms_t cnt_q, cnt_d;
  logic     ind_q, ind_d, use_act, busy, eff;

  always_comb begin
    use_act = act & (act_only | ~comb_dis);
    busy = ((cnt_q != '0) & (act_only | ~comb_dis)) | use_act;
    cnt_d = cnt_q;
    if (use_act) begin
      cnt_d = t_ms;
    end else if (ms_tick && cnt_q != '0) begin
      cnt_d = cnt_q - 9'h1;
    end
    eff = str_sel | blink_ph;
    ind_d = (base ^ (busy & eff)) & (~pulse_en | pwm_on);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ind_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ind_q <= ind_d;
    end
  end

  assign ind = ind_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PULSE_OFF: assert property (pulse_en && !pwm_on |=> !ind_q)
    else $error("pulsed output on during off phase");
  AST_COMB_DIS: assert property (comb_dis && !act_only && !pulse_en |=> ind_q == $past(base))
    else $error("combine-disabled output not showing base level");
  AST_STRETCH: assert property (use_act && str_sel && !pulse_en |=> ind_q == !$past(base))
    else $error("stretch did not invert output on activity");
endmodule
`default_nettype wire

// ---- pasl_led_mon.sv ----
// pasl_led_mon: indicator lamp model, counts lit cycles and changes per lamp
// assumes: lamps are driven on clk; clr restarts both counts
`timescale 1ns/1ps
`default_nettype none
module pasl_led_mon (
  // clock and control
  input  wire logic       clk,
  input  wire logic       clr,
  // lamps
  input  wire logic [3:0] ind,
  // counts
  output int              hi_cnt [4],
  output int              tg_cnt [4]
);
  logic [3:0] last_q;
  always @(posedge clk) begin
    last_q <= ind;
    for (int i = 0; i < 4; i++) begin
      hi_cnt[i] <= clr ? 0 : hi_cnt[i] + int'(ind[i]);
      tg_cnt[i] <= clr ? 0 : tg_cnt[i] + int'(ind[i] != last_q[i]);
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// testbench: register and indicator scenarios for pasl_top
// assumes: pasl_defs.svh, pasl_pkg and pasl_led_mon compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pasl_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench import pasl_pkg::*;;
  localparam int MS = 10;
  logic       clk, arst_n, reg_wr, reg_rd, an_en, an_done, link_up, automatic_media_sense;
  logic       fx_sel, xover, cd_swap, full_duplex_flag, link_cu, link_fi, tx_cu, rx_cu;
  logic       tx_fi, rx_fi, col, first_port, ps_en, clr;
  logic [4:0] reg_addr;
  pasl_word_t reg_wdata, reg_rdata;
  logic [3:0] pol_inv, ind;
  logic [1:0] speed, media, ps_timeout_code;
  logic [6:0] pwm_duty;
  pasl_rate_t rate_in, rate_out;
  int         hi_cnt [4];
  int         tg_cnt [4];
  int         err_total, n_checks;

  pasl_top #(.MS_CYC(MS), .PWM_CYC(200)) u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .an_en(an_en),
    .an_done(an_done), .link_up(link_up), .automatic_media_sense(automatic_media_sense),
    .fx_sel(fx_sel), .xover(xover), .cd_swap(cd_swap), .pol_inv(pol_inv),
    .full_duplex_flag(full_duplex_flag), .speed(speed), .media(media), .link_cu(link_cu),
    .link_fi(link_fi), .tx_cu(tx_cu), .rx_cu(rx_cu), .tx_fi(tx_fi), .rx_fi(rx_fi), .col(col),
    .pwm_duty(pwm_duty), .first_port(first_port), .rate_in(rate_in), .rate_out(rate_out),
    .ps_en(ps_en), .ps_timeout_code(ps_timeout_code), .indicator_output_zero(ind[0]),
    .indicator_output_one(ind[1]), .indicator_output_two(ind[2]), .indicator_output_three(ind[3]));
  pasl_led_mon u_mon (.clk(clk), .clr(clr), .ind(ind), .hi_cnt(hi_cnt), .tg_cnt(tg_cnt));

  function automatic pasl_word_t exp_aux(input logic [1:0] to, input logic pse);
    return {an_en ? an_done : link_up, ~an_en | (automatic_media_sense & fx_sel), xover, cd_swap,
            pol_inv, to[1], pse, full_duplex_flag, speed, to[0], media};
  endfunction
  function automatic pasl_word_t beh(input logic cd, as, pu, input logic [1:0] r, input logic st, lc);
    return {cd, as, 1'b0, pu, r, 1'b0, {4{st}}, 1'b0, {4{lc}}};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input pasl_word_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input pasl_word_t ex);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata)
  endtask
  task automatic cfg(input logic [3:0] m, input pasl_word_t b);
    wr(`PASL_A_MODE, {4{m}});
    wr(`PASL_A_BEH, b);
  endtask
  task automatic pulse(input logic [1:0] w);
    @(posedge clk);
    {rx_cu, tx_cu} <= w;
    @(posedge clk);
    {rx_cu, tx_cu} <= 2'h0;
  endtask
  task automatic meas(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cyc(n);
  endtask
  task automatic near(input string nm, input int c [4], input int lo, input int hi);
    for (int i = 0; i < 4; i++) `CHK(nm, 1'b1, c[i] >= lo && c[i] <= hi)
  endtask

  task automatic t_reset;
    `CHK("ps_en", 1'b0, ps_en)
    `CHK("ps_to", 2'h1, ps_timeout_code)
    `CHK("rate_out", 2'h1, rate_out)
    rd_chk("aux", `PASL_A_AUX, exp_aux(2'h1, 1'b0));
    rd_chk("mode", `PASL_A_MODE, 16'h8021);
    @(posedge clk);
    #1;
    `CHK("rdata_drop", 16'h0000, reg_rdata)
    rd_chk("beh", `PASL_A_BEH, 16'h0400);
    rd_chk("unmapped", 5'h1F, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_status;
    logic [15:0] p;
    for (int i = 0; i < 16; i++) begin
      p = 16'(i * 947) ^ 16'h5A3C;
      @(posedge clk);
      {an_en, an_done, link_up, automatic_media_sense, fx_sel, xover, cd_swap, full_duplex_flag} <= p[15:8];
      {pol_inv, speed, media} <= p[7:0];
      @(posedge clk);
      rd_chk("aux_status", `PASL_A_AUX, exp_aux(2'h1, 1'b0));
    end
    $display("test status done");
  endtask
  task automatic t_regs;
    wr(`PASL_A_AUX, 16'hFFFF);
    rd_chk("aux_wr", `PASL_A_AUX, exp_aux(2'h3, 1'b1));
    `CHK("ps_en", 1'b1, ps_en)
    `CHK("ps_to", 2'h3, ps_timeout_code)
    wr(`PASL_A_AUX, 16'h0080);
    rd_chk("aux_hi", `PASL_A_AUX, exp_aux(2'h2, 1'b0));
    for (int m = 0; m < 16; m++) begin
      wr(`PASL_A_MODE, {4'(m), 4'(15 - m), 4'(m ^ 5), 4'(m ^ 10)});
      rd_chk("mode_rw", `PASL_A_MODE, {4'(m), 4'(15 - m), 4'(m ^ 5), 4'(m ^ 10)});
    end
    wr(`PASL_A_BEH, 16'hFFFF);
    rd_chk("beh_rw", `PASL_A_BEH, 16'hDDEF);
    `CHK("rate_out", 2'h3, rate_out)
    wr(5'h1F, 16'h0000);
    rd_chk("beh_kept", `PASL_A_BEH, 16'hDDEF);
    $display("test registers done");
  endtask
  task automatic t_rate;
    for (int r = 0; r < 4; r++) begin
      cfg(4'hA, beh(1'b0, 1'b0, 1'b0, 2'(r), 1'b1, 1'b0));
      cyc(5);
      `CHK("rate_out", 2'(r), rate_out)
      pulse(2'b01);
      meas((400 >> r) * MS + 40);
      near("stretch", hi_cnt, (400 >> r) * MS - MS - 4, (400 >> r) * MS + MS + 4);
    end
    @(posedge clk);
    first_port <= 1'b0;
    rate_in <= 2'h3;
    cfg(4'hA, beh(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0));
    cyc(5);
    `CHK("rate_own", 2'h0, rate_out)
    pulse(2'b01);
    meas(540);
    near("shared_rate", hi_cnt, 50 * MS - MS - 4, 50 * MS + MS + 4);
    @(posedge clk);
    first_port <= 1'b1;
    $display("test rate done");
  endtask
  task automatic t_combine;
    link_fi <= 1'b1;
    cfg(4'h0, beh(1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b1));
    cyc(3);
    `CHK("fiber_link", 4'hF, ind)
    pulse(2'b01);
    cyc(3);
    `CHK("act_ignored", 4'hF, ind)
    wr(`PASL_A_BEH, beh(1'b1, 1'b0, 1'b0, 2'h3, 1'b1, 1'b1));
    cyc(3);
    `CHK("copper_only", 4'h0, ind)
    @(posedge clk);
    link_cu <= 1'b1;
    wr(`PASL_A_BEH, beh(1'b1, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0));
    pulse(2'b01);
    cyc(3);
    `CHK("link_act", 4'h0, ind)
    cyc(600);
    `CHK("link_back", 4'hF, ind)
    $display("test combine done");
  endtask
  task automatic t_split;
    cfg(4'hA, beh(1'b0, 1'b1, 1'b0, 2'h3, 1'b1, 1'b0));
    cyc(600);
    pulse(2'b10);
    cyc(3);
    `CHK("rx_hidden", 4'h0, ind)
    pulse(2'b01);
    cyc(3);
    `CHK("tx_shown", 4'hF, ind)
    wr(`PASL_A_MODE, 16'hBBBB);
    cyc(600);
    pulse(2'b01);
    cyc(3);
    `CHK("fi_tx_hidden", 4'h0, ind)
    pulse(2'b10);
    cyc(3);
    `CHK("fi_rx_shown", 4'hF, ind)
    wr(`PASL_A_MODE, 16'hAAAA);
    wr(`PASL_A_BEH, beh(1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0));
    cyc(600);
    pulse(2'b10);
    cyc(3);
    `CHK("rx_shown", 4'hF, ind)
    $display("test split done");
  endtask
  task automatic t_pulse;
    @(posedge clk);
    pwm_duty <= 7'd25;
    cfg(4'hF, beh(1'b0, 1'b0, 1'b1, 2'h3, 1'b1, 1'b0));
    cyc(600);
    meas(2000);
    near("duty25", hi_cnt, 460, 540);
    @(posedge clk);
    pwm_duty <= 7'd100;
    meas(2000);
    near("duty100", hi_cnt, 1980, 2002);
    @(posedge clk);
    pwm_duty <= 7'd0;
    wr(`PASL_A_BEH, beh(1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0));
    meas(2000);
    near("steady_on", hi_cnt, 1980, 2002);
    $display("test pulsing done");
  endtask
  task automatic t_blink;
    cfg(4'hA, beh(1'b0, 1'b0, 1'b0, 2'h3, 1'b0, 1'b0));
    tx_cu <= 1'b1;
    meas(2000);
    near("blink", tg_cnt, 7, 9);
    wr(`PASL_A_BEH, beh(1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0));
    meas(1000);
    near("stretch_steady", tg_cnt, 0, 0);
    @(posedge clk);
    tx_cu <= 1'b0;
    $display("test blink done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
  initial begin
    {arst_n, reg_wr, reg_rd, an_done, link_up, automatic_media_sense, fx_sel, xover} = 8'h00;
    {cd_swap, full_duplex_flag, link_cu, link_fi, tx_cu, rx_cu, tx_fi, rx_fi, col, clr} = 10'h000;
    {reg_addr, reg_wdata, pol_inv, speed, media, pwm_duty} = 38'h0;
    an_en = 1'b1;
    first_port = 1'b1;
    rate_in = 2'h1;
    err_total = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    cyc(3);
    t_reset;
    t_status;
    t_regs;
    t_rate;
    t_combine;
    t_split;
    t_pulse;
    t_blink;
    report_and_stop;
  end
endmodule
`default_nettype wire
